// ### afc_flow_ctrl.sv
// Automatic receive FIFO flow control: pause frames in full duplex, jamming in half duplex.
// Assumes MAC status, FIFO level and frame events come from logic on aclk; AXI4-Lite master on aclk.
//
// Notes on behaviour
// (R1) Nothing sent or jammed while transmitter disabled
// (R2) High threshold bits 23:16, 64-byte units
// (R3) Full duplex: one pause frame at high
// (R4) Half duplex: jam matching frames after high
// (R5) Below low threshold: send zero-time pause
// (R6) Zero pause only after real pause sent
// (R7) Software keeps low below high
// (R8) Jam length from bits 7:4, half only
// (R9) Bit 3: jam on multicast frames
// (R10) Bit 2: jam on broadcast frames
// (R11) Bit 1: jam on own-address frames
// (R12) Bit 0: react to any frame
// (R13) Any-frame bit overrides bits 3:1
// (R14) Jam code maps to fixed durations
// (R15) Pause request held until MAC sends
// (R16) High reached when fill >= high*64
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module afc_flow_ctrl
	import afc_pkg::*;
#(
	parameter int unsigned JAM_CYCLE_DIV = 1
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output var  logic                  s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output var  logic                  s_axi_wready,
	output var  logic [1:0]            s_axi_bresp,
	output var  logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output var  logic                  s_axi_arready,
	output var  logic [31:0]           s_axi_rdata,
	output var  logic [1:0]            s_axi_rresp,
	output var  logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  tx_enabled,
	input  wire logic                  full_duplex,
	input  wire logic                  speed_100,
	input  wire logic [AFC_FILL_W-1:0] rx_fifo_bytes,
	input  wire afc_rx_frame_t         rx_frame,
	input  wire logic                  pause_sent,
	output var  logic                  pause_req,
	output var  logic [15:0]           pause_time,
	output var  logic                  jam
);

	// ==========================================================
	// Registers and state
	flow_control_config_t                cfg_r;
	logic [15:0]             pause_time_value_r;
	afc_pause_st_t           state_r;
	logic [AFC_JAM_W-1:0]    jam_cnt_r;
	logic [7:0]              awaddr_r;
	logic [31:0]             wdata_r;
	logic [3:0]              wstrb_r;
	logic                    awready_r;
	logic                    wready_r;
	logic                    bvalid_r;
	logic [1:0]              bresp_r;
	logic                    arready_r;
	logic                    rvalid_r;
	logic [31:0]             rdata_r;
	logic [1:0]              rresp_r;
	logic                    pause_req_r;
	logic [15:0]             pause_time_r;
	logic                    jam_r;
	logic [AFC_FILL_W-1:0]   hi_bytes;
	logic [AFC_FILL_W-1:0]   lo_bytes;
	logic                    hi_reached;
	logic                    lo_below;
	logic                    frame_match;
	logic                    jam_start;
	logic                    do_write;

	// ==========================================================
	// Threshold and frame match
	assign hi_bytes    = AFC_FILL_W'({cfg_r.fifo_high_threshold, 6'h00});
	assign lo_bytes    = AFC_FILL_W'({cfg_r.fifo_low_threshold, 6'h00});
	assign hi_reached  = rx_fifo_bytes >= hi_bytes; // R16 R2
	assign lo_below    = rx_fifo_bytes < lo_bytes; // R5
	assign frame_match = rx_frame.start & (cfg_r.react_on_any_frame // R12 R13
		| (cfg_r.react_on_multicast & rx_frame.multicast) // R9
		| (cfg_r.react_on_broadcast & rx_frame.broadcast) // R10
		| (cfg_r.react_on_own_address & rx_frame.own_address)); // R11
	assign jam_start   = tx_enabled & ~full_duplex & hi_reached & frame_match & ~jam_r; // R4 R1

	function automatic logic [AFC_JAM_W-1:0] jam_cycles(input logic [3:0] code, input logic fast);
		int unsigned ns;
		int unsigned c;
		ns = AFC_JAM_100_NS[code] + (fast ? 0 : AFC_JAM_ADD_10_NS);
		c  = ns / AFC_CLK_PERIOD_NS / JAM_CYCLE_DIV;
		if (c == 0) begin
			c = 1;
		end
		return AFC_JAM_W'(c);
	endfunction : jam_cycles

	// ==========================================================
	// AXI4-Lite write channel
	assign do_write = ~awready_r & ~wready_r & ~bvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			awaddr_r  <= 8'h00;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			awaddr_r  <= s_axi_awaddr;
		end else if (bvalid_r && s_axi_bready) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b1;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (bvalid_r && s_axi_bready) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= AFC_RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (awaddr_r == FLOW_CONTROL_CONFIG_OFF || awaddr_r == AFC_PAUSE_OFF || awaddr_r == AFC_STAT_OFF)
				? AFC_RESP_OKAY : AFC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r              <= flow_control_config_t'(FLOW_CONTROL_CONFIG_RESET);
			pause_time_value_r <= AFC_PAUSE_RESET;
		end else if (do_write) begin
			if (awaddr_r == FLOW_CONTROL_CONFIG_OFF) begin
				cfg_r <= flow_control_config_t'({wstrb_r[2] ? wdata_r[23:16] : cfg_r[23:16],
					wstrb_r[1] ? wdata_r[15:8] : cfg_r[15:8],
					wstrb_r[0] ? wdata_r[7:0] : cfg_r[7:0]});
			end
			if (awaddr_r == AFC_PAUSE_OFF) begin
				pause_time_value_r <= {wstrb_r[1] ? wdata_r[15:8] : pause_time_value_r[15:8],
					wstrb_r[0] ? wdata_r[7:0] : pause_time_value_r[7:0]};
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= AFC_RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= AFC_RESP_OKAY;
			unique case (s_axi_araddr)
				FLOW_CONTROL_CONFIG_OFF:   rdata_r <= {8'h00, cfg_r};
				AFC_PAUSE_OFF: rdata_r <= {16'h0000, pause_time_value_r};
				AFC_STAT_OFF:  rdata_r <= {10'h000, jam_cnt_r, jam_r, pause_req_r, 2'(state_r), lo_below, hi_reached};
				default: begin
					rdata_r <= 32'h00000000;
					rresp_r <= AFC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// ==========================================================
	// Full-duplex pause sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= AFC_IDLE;
		end else begin
			unique case (state_r)
				AFC_IDLE:
					if (tx_enabled && full_duplex && cfg_r.react_on_any_frame && hi_reached) begin // R3 R12 R1
						state_r <= AFC_SEND_ON;
					end
				AFC_SEND_ON:
					if (!tx_enabled) begin // R1
						state_r <= AFC_IDLE;
					end else if (pause_sent) begin // R15 R6
						state_r <= AFC_PAUSED;
					end
				AFC_PAUSED:
					if (tx_enabled && lo_below && (|cfg_r[3:0])) begin // R5 R6
						state_r <= AFC_SEND_OFF;
					end
				AFC_SEND_OFF:
					if (!tx_enabled) begin // R1
						state_r <= AFC_PAUSED;
					end else if (pause_sent) begin
						state_r <= AFC_IDLE;
					end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pause_req_r  <= 1'b0;
			pause_time_r <= 16'h0000;
		end else if (!tx_enabled || pause_sent) begin // R1 R15
			pause_req_r  <= 1'b0;
		end else if (state_r == AFC_IDLE && full_duplex && cfg_r.react_on_any_frame && hi_reached) begin
			pause_req_r  <= 1'b1; // R3
			pause_time_r <= pause_time_value_r;
		end else if (state_r == AFC_PAUSED && lo_below && (|cfg_r[3:0])) begin
			pause_req_r  <= 1'b1; // R5
			pause_time_r <= 16'h0000;
		end
	end

	// ==========================================================
	// Half-duplex jam timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			jam_r     <= 1'b0;
			jam_cnt_r <= '0;
		end else if (!tx_enabled || full_duplex) begin // R1 R8
			jam_r     <= 1'b0;
			jam_cnt_r <= '0;
		end else if (jam_start) begin
			jam_r     <= 1'b1; // R4
			jam_cnt_r <= jam_cycles(cfg_r.jam_duration_code, speed_100); // R8 R14
		end else if (jam_r) begin
			jam_cnt_r <= jam_cnt_r - 1'b1;
			jam_r     <= jam_cnt_r > 1;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign pause_req     = pause_req_r;
	assign pause_time    = pause_time_r;
	assign jam           = jam_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	no_tx_idle_a: assert property (!tx_enabled |=> !pause_req_r && !jam_r) // R1
		else $error("pause or jam while transmitter disabled");
	hi_trigger_a: assert property (state_r == AFC_IDLE && tx_enabled && full_duplex
		&& cfg_r.react_on_any_frame && rx_fifo_bytes >= {cfg_r.fifo_high_threshold, 6'h00}
		|=> pause_req_r && pause_time_r == $past(pause_time_value_r)) // R2
		else $error("pause not requested at high level");
	single_pause_a: assert property (state_r == AFC_SEND_ON && pause_sent && tx_enabled
		|=> state_r == AFC_PAUSED ##1 !pause_req_r || pause_time_r == 16'h0000) // R3
		else $error("second nonzero pause frame requested");
	jam_start_a: assert property (jam_start |=> jam_r [*2] or (jam_r ##1 1'b1)) // R4
		else $error("matching frame not jammed");
	zero_pause_a: assert property (state_r == AFC_PAUSED && tx_enabled && lo_below && (|cfg_r[3:0])
		|=> pause_req_r && pause_time_r == 16'h0000) // R5
		else $error("zero pause not requested below low level");
	zero_only_after_a: assert property ($rose(pause_req_r) && pause_time_r == 16'h0000
		|-> $past(state_r) == AFC_PAUSED) // R6
		else $error("zero pause without prior pause");
	jam_length_a: assert property (jam_start |=> jam_cnt_r == jam_cycles($past(cfg_r.jam_duration_code),
		$past(speed_100))) // R8
		else $error("jam duration load wrong");
	jam_mult_a: assert property (tx_enabled && !full_duplex && hi_reached && !jam_r && rx_frame.start
		&& rx_frame.multicast && cfg_r.react_on_multicast |=> jam_r) // R9
		else $error("multicast frame not jammed");
	any_override_a: assert property (tx_enabled && !full_duplex && hi_reached && !jam_r && rx_frame.start
		&& cfg_r.react_on_any_frame |=> jam_r) // R13
		else $error("any-frame selection ignored");
	fd_no_jam_a: assert property (full_duplex |=> !jam_r) // R8
		else $error("jam in full duplex");
	req_held_a: assert property (pause_req_r && tx_enabled && !pause_sent |=> pause_req_r) // R15
		else $error("pause request dropped before sent");

	pause_cycle_c: cover property (state_r == AFC_PAUSED ##[1:1000] state_r == AFC_IDLE);
	jam_run_c: cover property ($rose(jam_r) ##[1:1000] $fell(jam_r));
	axi_write_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == AFC_RESP_OKAY);

endmodule : afc_flow_ctrl
`default_nettype wire

// ### afc_pkg.sv
// Constants and carrier types for the receive FIFO flow controller.
// Assumes a 100 MHz register clock shared with the MAC receive and transmit logic.
`default_nettype none
package afc_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0]  FLOW_CONTROL_CONFIG_OFF       = 8'hAC;
	localparam logic [7:0]  AFC_PAUSE_OFF     = 8'hB4;
	localparam logic [7:0]  AFC_STAT_OFF      = 8'hB8;
	localparam logic [23:0] FLOW_CONTROL_CONFIG_RESET     = 24'h000000;
	localparam logic [15:0] AFC_PAUSE_RESET   = 16'h0000;
	localparam logic [1:0]  AFC_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  AFC_RESP_SLVERR   = 2'h2;

	// ==========================================================
	// Field positions of the configuration register
	localparam int unsigned FIFO_HIGH_THRESHOLD_LSB        = 16;
	localparam int unsigned FIFO_LOW_THRESHOLD_LSB        = 8;
	localparam int unsigned AFC_DUR_LSB       = 4;
	localparam int unsigned AFC_MULT_BIT      = 3;
	localparam int unsigned AFC_BRD_BIT       = 2;
	localparam int unsigned AFC_ADD_BIT       = 1;
	localparam int unsigned AFC_ANY_BIT       = 0;
	localparam int unsigned AFC_UNIT_SHIFT    = 6;
	localparam int unsigned AFC_FILL_W        = 14;

	// ==========================================================
	// Timing
	localparam int unsigned AFC_CLK_PERIOD_NS = 10;
	localparam int unsigned AFC_JAM_ADD_10_NS = 2200;
	localparam int unsigned AFC_JAM_100_NS [0:15] = '{
		5000, 10000, 15000, 25000, 50000, 100000, 150000, 200000,
		250000, 300000, 350000, 400000, 450000, 500000, 550000, 600000};
	localparam int unsigned AFC_JAM_W         = 16;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [7:0] fifo_high_threshold;
		logic [7:0] fifo_low_threshold;
		logic [3:0] jam_duration_code;
		logic       react_on_multicast;
		logic       react_on_broadcast;
		logic       react_on_own_address;
		logic       react_on_any_frame;
	} flow_control_config_t;

	typedef struct packed {
		logic start;
		logic multicast;
		logic broadcast;
		logic own_address;
	} afc_rx_frame_t;

	typedef enum logic [1:0] {
		AFC_IDLE,
		AFC_SEND_ON,
		AFC_PAUSED,
		AFC_SEND_OFF
	} afc_pause_st_t;

endpackage : afc_pkg
`default_nettype wire

// ### afc_mac_tx_model.sv
// MAC transmitter stand-in that sends the pause frames the flow controller asks for.
// Assumes aclk and aresetn are shared with the flow controller.
`timescale 1ns/1ps
`default_nettype none
module afc_mac_tx_model #(
	parameter int unsigned DELAY = 4
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pause_req,
	output var  logic pause_sent
);
	// ==========================================================
	// Queue the request, send it in the next window
	int unsigned wait_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_r     <= 0;
			pause_sent <= 1'b0;
		end else begin
			pause_sent <= 1'b0;
			if (!pause_req) begin
				wait_r <= 0;
			end else if (wait_r == DELAY) begin
				pause_sent <= 1'b1;
				wait_r     <= wait_r + 1;
			end else if (wait_r < DELAY) begin
				wait_r <= wait_r + 1;
			end
		end
	end
endmodule : afc_mac_tx_model
`default_nettype wire

// ### tb_afc_flow_ctrl.sv
// Self-checking bench for the receive FIFO flow controller.
// Assumes a 100 MHz clock and JAM_CYCLE_DIV of 100 to keep jam counts short.
`timescale 1ns/1ps
`default_nettype none
module tb_afc_flow_ctrl;
	import afc_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, tx_en, fdx, spd, psent, preq, jam;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [13:0] fill;
	logic [15:0] ptime;
	afc_rx_frame_t frame;
	int          failures, cmp_count;

	afc_flow_ctrl #(.JAM_CYCLE_DIV(100)) i_afc_flow_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tx_enabled(tx_en), .full_duplex(fdx), .speed_100(spd),
		.rx_fifo_bytes(fill), .rx_frame(frame), .pause_sent(psent), .pause_req(preq),
		.pause_time(ptime), .jam(jam));
	afc_mac_tx_model i_afc_mac_tx_model (.aclk(aclk), .aresetn(aresetn), .pause_req(preq), .pause_sent(psent));

	// ==========================================================
	// Report and bus tasks
	task close_out;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// ==========================================================
	// Scenarios
	task reg_test;
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(FLOW_CONTROL_CONFIG_OFF, d, r);
		chk("cfg_reset", 32'h0, d);
		axi_wr(FLOW_CONTROL_CONFIG_OFF, 32'hFF02015A, r);
		axi_rd(FLOW_CONTROL_CONFIG_OFF, d, r);
		chk("cfg_readback", 32'h0002015A, d);
		axi_wr(AFC_PAUSE_OFF, 32'h00001234, r);
		axi_rd(AFC_PAUSE_OFF, d, r);
		chk("pause_value", 32'h1234, d);
		axi_rd(8'hC0, d, r);
		chk("unmapped_rresp", {30'h0, AFC_RESP_SLVERR}, {30'h0, r});
		axi_wr(8'hC0, 32'h1, r);
		chk("unmapped_bresp", {30'h0, AFC_RESP_SLVERR}, {30'h0, r});
	endtask : reg_test

	task full_dup;
		logic [1:0] r;
		fdx <= 1'b1;
		axi_wr(FLOW_CONTROL_CONFIG_OFF, 32'h00020101, r);
		fill <= 14'd63; repeat (4) @(posedge aclk);
		chk("no_zero_pause", 0, preq);
		fill <= 14'd127; repeat (4) @(posedge aclk);
		chk("below_high", 0, preq);
		fill <= 14'd128; repeat (2) @(posedge aclk);
		chk("pause_on", 1, preq);
		chk("pause_on_time", 32'h1234, ptime);
		repeat (12) @(posedge aclk);
		chk("single_pause", 0, preq);
		fill <= 14'd64; repeat (4) @(posedge aclk);
		chk("at_low", 0, preq);
		fill <= 14'd63; repeat (2) @(posedge aclk);
		chk("pause_off", 1, preq);
		chk("pause_off_time", 0, ptime);
		repeat (12) @(posedge aclk);
		chk("pause_off_done", 0, preq);
		tx_en <= 1'b0; fill <= 14'd200; repeat (8) @(posedge aclk);
		chk("tx_off_pause", 0, preq);
		fill <= 14'd0; tx_en <= 1'b1;
		axi_wr(FLOW_CONTROL_CONFIG_OFF, 32'h00020108, r);
		fill <= 14'd200; repeat (8) @(posedge aclk);
		chk("mcast_full_dup", 0, preq);
		fill <= 14'd0; fdx <= 1'b0;
	endtask : full_dup

	task jcase(input logic [7:0] low, input logic s, input logic t, input logic [13:0] f,
		input logic [3:0] fr, input int e);
		logic [1:0] r;
		int         n;
		axi_wr(FLOW_CONTROL_CONFIG_OFF, {16'h0002, 8'h01, low}, r);
		spd <= s; tx_en <= t; fill <= f;
		@(posedge aclk); frame <= fr;
		@(posedge aclk); frame <= '0;
		@(posedge aclk);
		n = 0;
		while (jam === 1'b1 && n < 1000) begin
			n++;
			@(posedge aclk);
		end
		chk("jam_cycles", 32'(e), 32'(n));
		tx_en <= 1'b1; fill <= 14'd0;
	endtask : jcase

	// ==========================================================
	// Clock, reset, sequence, watchdog
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		close_out;
	end

	initial begin
		aresetn = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF; tx_en = 1; fdx = 0; spd = 1;
		fill = '0; frame = '0; failures = 0; cmp_count = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		reg_test;
		full_dup;
		jcase(8'h08, 1, 1, 14'd128, 4'hC, 5);
		jcase(8'h08, 1, 1, 14'd128, 4'hA, 0);
		jcase(8'h04, 1, 1, 14'd128, 4'hA, 5);
		jcase(8'h02, 1, 1, 14'd128, 4'h9, 5);
		jcase(8'h02, 1, 1, 14'd128, 4'hC, 0);
		jcase(8'h01, 1, 1, 14'd128, 4'h8, 5);
		jcase(8'h01, 1, 1, 14'd127, 4'h8, 0);
		jcase(8'h01, 1, 0, 14'd128, 4'h8, 0);
		jcase(8'hF1, 1, 1, 14'd128, 4'h8, 600);
		jcase(8'h01, 0, 1, 14'd128, 4'h8, 7);
		close_out;
	end
endmodule : tb_afc_flow_ctrl
`default_nettype wire
